/* File: pkg/mpcs_consts.svh */
`ifndef MPCS_CONSTS_SVH
`define MPCS_CONSTS_SVH

// Register byte addresses
`define MPCS_ADDR_OSC_CTRL    8'h20
`define MPCS_ADDR_PLL_CTRL    8'h2c
`define MPCS_ADDR_MCK_CFG     8'h30
`define MPCS_ADDR_PCK_BASE    8'h40
`define MPCS_ADDR_PCK_STEP    8'h04
`define MPCS_ADDR_IRQ_SET     8'h60
`define MPCS_ADDR_IRQ_CLR     8'h64
`define MPCS_ADDR_STATUS      8'h68
`define MPCS_ADDR_MASK_VIEW   8'h6c
`define MPCS_ADDR_EVENT       8'h70

// Shared flag layout of enable, disable, status, mask and event registers
`define MPCS_BIT_OSC_STABLE   0
`define MPCS_BIT_PLL_LOCK     2
`define MPCS_BIT_MCK_READY    3
`define MPCS_BIT_PCK0_READY   8
`define MPCS_FLAG_MASK        32'h0000070d

// Clock configuration fields
`define MPCS_CFG_SRC_LSB      0
`define MPCS_CFG_SRC_MSB      1
`define MPCS_CFG_PRESCALE_SELECT_LSB     2
`define MPCS_CFG_PRESCALE_SELECT_MSB     4
`define MPCS_CFG_RESET        5'h00
`define MPCS_PRESCALE_SELECT_RESERVED    3'h7

// Oscillator control fields
`define MPCS_OSC_EN_BIT       0
`define MPCS_OSC_BYP_BIT      1
`define MPCS_OSC_CNT_LSB      8
`define MPCS_OSC_CNT_MSB      15
`define MPCS_OSC_CNT_SHIFT    3
`define MPCS_OSC_RESET        32'h00000000

// PLL control wait field
`define MPCS_PLL_CNT_LSB      8
`define MPCS_PLL_CNT_MSB      13
`define MPCS_PLL_RESET        32'h00000000

// Divided-output ticks seen before a new clock counts as glitch-free
`define MPCS_SETTLE_TICKS     2'h2

`endif

/* File: pkg/mpcs_pkg.sv */
package mpcs_pkg;

  typedef enum logic [1:0] {
    MPCS_SRC_SLOW,
    MPCS_SRC_MAIN,
    MPCS_SRC_RSVD,
    MPCS_SRC_PLL
  } mpcs_src_e;

  typedef struct packed {
    logic [2:0] prescale_select;
    logic [1:0] clock_source_select;
  } mpcs_clk_cfg_s;

  typedef struct packed {
    logic slow;
    logic main;
    logic pll;
  } mpcs_ticks_s;

endpackage : mpcs_pkg

/* File: logic/mpcs_clk_div.sv */
`timescale 1ns/100ps
`include "mpcs_consts.svh"

module mpcs_clk_div
  import mpcs_pkg::*;
(
  input  wire logic          i_clk,     // System clock
  input  wire logic          i_reset_n, // Async reset, active low
  input  wire mpcs_clk_cfg_s i_cfg,     // Source and prescale
  input  wire mpcs_ticks_s   i_ticks,   // Source clock enables
  output logic               o_tick,    // Divided clock enable pulse
  output logic               o_ready    // Clock settled after change
);

  mpcs_clk_cfg_s cfg_prev;
  mpcs_clk_cfg_s next_cfg_prev;
  logic [5:0]    cnt;
  logic [5:0]    next_cnt;
  logic [1:0]    settle;
  logic [1:0]    next_settle;
  logic          next_tick;
  logic          next_ready;
  logic          src_tick;
  logic [5:0]    limit;

  always_comb begin
    case (i_cfg.clock_source_select)
      2'h0:    src_tick = i_ticks.slow;
      2'h1:    src_tick = i_ticks.main;
      2'h3:    src_tick = i_ticks.pll;
      default: src_tick = 1'b0;
    endcase
    limit = 6'((7'h01 << i_cfg.prescale_select) - 7'h01);
  end

  always_comb begin
    next_cfg_prev = i_cfg;
    next_cnt      = cnt;
    next_settle   = settle;
    next_tick     = 1'b0;
    next_ready    = o_ready;
    if (i_cfg != cfg_prev) begin
      // Restart from a clean phase so no runt pulse reaches the output
      next_cnt    = 6'h00;
      next_settle = 2'h0;
      next_ready  = 1'b0;
    end else if (src_tick && i_cfg.prescale_select != `MPCS_PRESCALE_SELECT_RESERVED) begin
      if (cnt >= limit) begin
        next_cnt  = 6'h00;
        next_tick = 1'b1;
        if (settle != `MPCS_SETTLE_TICKS) begin
          next_settle = 2'(settle + 2'h1);
        end
        if (settle == 2'(`MPCS_SETTLE_TICKS - 2'h1)) begin
          next_ready = 1'b1;
        end
      end else begin
        next_cnt = 6'(cnt + 6'h01);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_prev <= `MPCS_CFG_RESET;
      cnt      <= 6'h00;
      settle   <= 2'h0;
      o_tick   <= 1'b0;
      o_ready  <= 1'b0;
    end else begin
      cfg_prev <= next_cfg_prev;
      cnt      <= next_cnt;
      settle   <= next_settle;
      o_tick   <= next_tick;
      o_ready  <= next_ready;
    end
  end

endmodule : mpcs_clk_div

/* File: logic/mpcs_top.sv */
// Function
// - The master clock source follows the two-bit source field: 00 slow, 01 main, 11 PLL, 10 reserved.
// - The selected master source is divided by 1, 2, 4, 8, 16, 32 or 64 for prescale codes 0 to 6; 7 is reserved.
// - Each programmable clock has its own register with a source field and a prescaler coded like the master one.
// - Three programmable clocks 0 to 2 exist, with ready flags at status bits 8, 9 and 10.
// - Writing one to an interrupt-enable bit enables that interrupt; a zero leaves it unchanged.
// - Writing one to an interrupt-disable bit disables that interrupt; a zero leaves it unchanged.
// - The mask view reads zero for an enabled interrupt and one for a disabled one.
// - Status bit 0 is one when the main oscillator is stable and zero otherwise.
// - Status bit 2 is one when the PLL is locked and zero otherwise.
// - Status bit 3 is one when the master clock is ready and zero otherwise.
// - Enable, disable, status and mask share one layout: bits 0, 2, 3 and 8 to 10, the rest unused.
// - After the PLL control register is written, lock sets only after the programmed slow clock count.
// - With the oscillator enabled, stable sets after the programmed count times 8 slow ticks; bypass sets it at once.
// - Clearing both oscillator enable and bypass clears the stable flag.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "mpcs_consts.svh"

module mpcs_top
  import mpcs_pkg::*;
#(
  parameter int NUM_PCK = 3 // Programmable clock outputs
) (
  input  wire logic               i_clk,         // System clock, 40 MHz
  input  wire logic               i_reset_n,     // Async reset, active low
  input  wire logic [7:0]         i_addr,        // Register byte address
  input  wire logic [31:0]        i_wdata,       // Write data
  input  wire logic               i_wr,          // Write strobe
  input  wire logic               i_rd,          // Read strobe
  output logic      [31:0]        o_rdata,       // Read data, cycle after strobe
  input  wire logic               i_slow_tick,   // Slow clock enable
  input  wire logic               i_main_tick,   // Main clock enable
  input  wire logic               i_pll_tick,    // PLL clock enable
  output logic                    o_master_tick, // Master clock enable
  output logic      [NUM_PCK-1:0] o_prog_tick,   // Programmable clock enables
  output logic                    o_irq          // Interrupt, level
);

  localparam int NUM_DIV = NUM_PCK + 1;

  // Configuration registers; index 0 is the master clock
  mpcs_clk_cfg_s cfg      [NUM_DIV];
  mpcs_clk_cfg_s next_cfg [NUM_DIV];
  logic [31:0]   osc_ctrl;
  logic [31:0]   next_osc_ctrl;
  logic [31:0]   pll_ctrl;
  logic [31:0]   next_pll_ctrl;
  logic [31:0]   irq_en;
  logic [31:0]   next_irq_en;
  logic [31:0]   event_flags;
  logic [31:0]   next_event_flags;
  logic [31:0]   status_prev;
  logic [31:0]   next_rdata;
  logic          next_irq;

  // Start-up and lock timers
  logic [10:0]   osc_cnt;
  logic [10:0]   next_osc_cnt;
  logic          osc_run;
  logic          next_osc_run;
  logic          osc_stable;
  logic          next_osc_stable;
  logic [5:0]    pll_cnt;
  logic [5:0]    next_pll_cnt;
  logic          pll_run;
  logic          next_pll_run;
  logic          pll_lock;
  logic          next_pll_lock;

  logic [NUM_DIV-1:0] div_tick;
  logic [NUM_DIV-1:0] div_ready;
  logic [NUM_DIV-1:0] cfg_hit;
  logic               wr_osc;
  logic               wr_pll;
  logic               wr_event;
  logic [31:0]        status;
  mpcs_ticks_s        ticks;

  assign ticks = '{slow: i_slow_tick, main: i_main_tick, pll: i_pll_tick};

  // Write decodes shared by the timers and the event register
  assign wr_osc   = i_wr && (i_addr == `MPCS_ADDR_OSC_CTRL);
  assign wr_pll   = i_wr && (i_addr == `MPCS_ADDR_PLL_CTRL);
  assign wr_event = i_wr && (i_addr == `MPCS_ADDR_EVENT);

  genvar g;
  generate
    // One divider per clock; index 0 is the master, the rest the programmable outputs
    for (g = 0; g < NUM_DIV; g++) begin : g_div
      if (g == 0) begin : g_mck
        assign cfg_hit[g] = (i_addr == `MPCS_ADDR_MCK_CFG);
      end else begin : g_pck
        assign cfg_hit[g] = (i_addr == 8'(`MPCS_ADDR_PCK_BASE + (g - 1) * `MPCS_ADDR_PCK_STEP));
      end
      mpcs_clk_div u_div (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_cfg     (cfg[g]),
        .i_ticks   (ticks),
        .o_tick    (div_tick[g]),
        .o_ready   (div_ready[g])
      );
    end
  endgenerate

  always_comb begin
    status                        = 32'h00000000;
    status[`MPCS_BIT_OSC_STABLE]  = osc_stable;
    status[`MPCS_BIT_PLL_LOCK]    = pll_lock;
    status[`MPCS_BIT_MCK_READY]   = div_ready[0];
    status[`MPCS_BIT_PCK0_READY +: NUM_PCK] = div_ready[NUM_DIV-1:1];
  end

  // Configuration and interrupt enable registers
  always_comb begin
    next_osc_ctrl = osc_ctrl;
    next_pll_ctrl = pll_ctrl;
    next_irq_en   = irq_en;
    // Clock configuration addresses are matched per divider in the generate loop
    for (int i = 0; i < NUM_DIV; i++) begin
      next_cfg[i] = cfg[i];
      if (i_wr && cfg_hit[i]) begin
        next_cfg[i] = i_wdata[`MPCS_CFG_PRESCALE_SELECT_MSB:`MPCS_CFG_SRC_LSB];
      end
    end
    if (i_wr) begin
      case (i_addr)
        `MPCS_ADDR_OSC_CTRL: next_osc_ctrl = i_wdata;
        `MPCS_ADDR_PLL_CTRL: next_pll_ctrl = i_wdata;
        `MPCS_ADDR_IRQ_SET:  next_irq_en   = irq_en | (i_wdata & `MPCS_FLAG_MASK);
        `MPCS_ADDR_IRQ_CLR:  next_irq_en   = irq_en & ~(i_wdata & `MPCS_FLAG_MASK);
        default:             next_irq_en   = irq_en;
      endcase
    end
  end

  // Oscillator start-up and PLL lock timers
  always_comb begin
    next_osc_cnt    = osc_cnt;
    next_osc_run    = osc_run;
    next_osc_stable = osc_stable;
    if (wr_osc) begin
      if (i_wdata[`MPCS_OSC_BYP_BIT]) begin
        next_osc_run    = 1'b0;
        next_osc_stable = 1'b1;
      end else if (i_wdata[`MPCS_OSC_EN_BIT]) begin
        // Rewriting with the oscillator on restarts the wait
        next_osc_cnt    = 11'({i_wdata[`MPCS_OSC_CNT_MSB:`MPCS_OSC_CNT_LSB], 3'h0});
        next_osc_run    = 1'b1;
        next_osc_stable = 1'b0;
      end else begin
        next_osc_run    = 1'b0;
        next_osc_stable = 1'b0;
      end
    end else if (osc_run) begin
      if (osc_cnt == 11'h000) begin
        next_osc_run    = 1'b0;
        next_osc_stable = 1'b1;
      end else if (i_slow_tick) begin
        next_osc_cnt = 11'(osc_cnt - 11'h001);
      end
    end
  end

  always_comb begin
    next_pll_cnt  = pll_cnt;
    next_pll_run  = pll_run;
    next_pll_lock = pll_lock;
    if (wr_pll) begin
      next_pll_cnt  = i_wdata[`MPCS_PLL_CNT_MSB:`MPCS_PLL_CNT_LSB];
      next_pll_run  = 1'b1;
      next_pll_lock = 1'b0;
    end else if (pll_run) begin
      if (pll_cnt == 6'h00) begin
        next_pll_run  = 1'b0;
        next_pll_lock = 1'b1;
      end else if (i_slow_tick) begin
        next_pll_cnt = 6'(pll_cnt - 6'h01);
      end
    end
  end

  // Sticky rising-edge events, write one to clear; a new edge beats the clear
  always_comb begin
    next_event_flags = event_flags;
    if (wr_event) begin
      next_event_flags = event_flags & ~i_wdata;
    end
    next_event_flags = (next_event_flags | (status & ~status_prev)) & `MPCS_FLAG_MASK;
  end

  // Level interrupt from live flags, not from the sticky events
  always_comb begin
    next_irq = |(status & irq_en);
  end

  // Read mux; write-only registers and holes read as zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        `MPCS_ADDR_OSC_CTRL:  next_rdata = osc_ctrl;
        `MPCS_ADDR_PLL_CTRL:  next_rdata = pll_ctrl;
        `MPCS_ADDR_MCK_CFG:   next_rdata = 32'(cfg[0]);
        `MPCS_ADDR_STATUS:    next_rdata = status;
        `MPCS_ADDR_MASK_VIEW: next_rdata = ~irq_en & `MPCS_FLAG_MASK;
        `MPCS_ADDR_EVENT:     next_rdata = event_flags;
        default: begin
          for (int i = 1; i < NUM_DIV; i++) begin
            if (cfg_hit[i]) begin
              next_rdata = 32'(cfg[i]);
            end
          end
        end
      endcase
    end
  end

  // Configuration and enable state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NUM_DIV; i++) begin
        cfg[i] <= `MPCS_CFG_RESET;
      end
      osc_ctrl <= `MPCS_OSC_RESET;
      pll_ctrl <= `MPCS_PLL_RESET;
      irq_en   <= 32'h00000000;
    end else begin
      for (int i = 0; i < NUM_DIV; i++) begin
        cfg[i] <= next_cfg[i];
      end
      osc_ctrl <= next_osc_ctrl;
      pll_ctrl <= next_pll_ctrl;
      irq_en   <= next_irq_en;
    end
  end

  // Oscillator start-up timer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_cnt    <= 11'h000;
      osc_run    <= 1'b0;
      osc_stable <= 1'b0;
    end else begin
      osc_cnt    <= next_osc_cnt;
      osc_run    <= next_osc_run;
      osc_stable <= next_osc_stable;
    end
  end

  // PLL lock timer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pll_cnt  <= 6'h00;
      pll_run  <= 1'b0;
      pll_lock <= 1'b0;
    end else begin
      pll_cnt  <= next_pll_cnt;
      pll_run  <= next_pll_run;
      pll_lock <= next_pll_lock;
    end
  end

  // Previous status is kept so that only rising edges set an event
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      event_flags <= 32'h00000000;
      status_prev <= 32'h00000000;
    end else begin
      event_flags <= next_event_flags;
      status_prev <= status;
    end
  end

  // Interrupt level, one cycle behind flags and enables
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end

  // Read data; zero outside the cycle after a read strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // Enables are re-registered so every output leaves a flip-flop, at one cycle of latency
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_master_tick <= 1'b0;
      o_prog_tick   <= '0;
    end else begin
      o_master_tick <= div_tick[0];
      o_prog_tick   <= div_tick[NUM_DIV-1:1];
    end
  end

endmodule : mpcs_top

/* File: bench/mpcs_top_props.sv */
`timescale 1ns/100ps
`include "mpcs_consts.svh"

module mpcs_top_props
  import mpcs_pkg::*;
#(
  parameter int NUM_PCK = 3 // Programmable clocks
) (
  input wire logic               i_clk,         // Clock
  input wire logic               i_reset_n,     // Reset, active low
  input wire logic [7:0]         i_addr,        // Address
  input wire logic [31:0]        i_wdata,       // Write data
  input wire logic               i_wr,          // Write strobe
  input wire logic               i_rd,          // Read strobe
  input wire logic [31:0]        o_rdata,       // Read data
  input wire logic               i_slow_tick,   // Slow enable
  input wire logic               i_main_tick,   // Main enable
  input wire logic               i_pll_tick,    // PLL enable
  input wire logic               o_master_tick, // Master enable
  input wire logic [NUM_PCK-1:0] o_prog_tick,   // Prog enables
  input wire logic               o_irq          // Interrupt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  wire logic mk_rd  = i_rd && i_addr == `MPCS_ADDR_MASK_VIEW;
  wire logic wo_rd  = i_rd && (i_addr == `MPCS_ADDR_IRQ_SET || i_addr == `MPCS_ADDR_IRQ_CLR);
  wire logic set_wr = i_wr && i_addr == `MPCS_ADDR_IRQ_SET;
  wire logic clr_wr = i_wr && i_addr == `MPCS_ADDR_IRQ_CLR;
  wire logic mck_a  = i_addr == `MPCS_ADDR_MCK_CFG;
  wire logic pck_a  = i_addr inside {8'h40, 8'h44, 8'h48};

  a_wo_reads_zero: assert property ($past(wo_rd) |-> o_rdata == 32'h0)
    else $error("write-only register read nonzero");
  a_status_layout: assert property ($past(i_rd && i_addr == `MPCS_ADDR_STATUS)
    |-> (o_rdata & ~`MPCS_FLAG_MASK) == 32'h0) else $error("status unused bit set");
  a_mask_layout: assert property ($past(mk_rd) |-> (o_rdata & ~`MPCS_FLAG_MASK) == 32'h0)
    else $error("mask view unused bit set");
  a_enable_set: assert property ($past(set_wr, 3) && !$past(i_wr, 2) && $past(mk_rd)
    |-> (o_rdata & $past(i_wdata, 3) & `MPCS_FLAG_MASK) == 32'h0) else $error("enable not shown in mask");
  a_enable_clear: assert property ($past(clr_wr, 3) && !$past(i_wr, 2) && $past(mk_rd)
    |-> (o_rdata & $past(i_wdata, 3) & `MPCS_FLAG_MASK) == ($past(i_wdata, 3) & `MPCS_FLAG_MASK))
    else $error("disable not shown in mask");
  a_irq_off: assert property (clr_wr && i_wdata == `MPCS_FLAG_MASK ##1 !i_wr [*2] |=> !o_irq)
    else $error("interrupt high with all disabled");
  a_mck_readback: assert property ($past(i_wr && mck_a, 3) && !$past(i_wr, 2) && $past(i_rd && mck_a)
    |-> o_rdata == {27'h0, $past(i_wdata[4:0], 3)}) else $error("master config readback wrong");
  a_pck_readback: assert property ($past(i_wr && pck_a, 3) && !$past(i_wr, 2) && $past(i_rd)
    && $past(i_addr) == $past(i_addr, 3) |-> o_rdata == {27'h0, $past(i_wdata[4:0], 3)})
    else $error("prog config readback wrong");
endmodule : mpcs_top_props

bind mpcs_top mpcs_top_props #(.NUM_PCK(NUM_PCK)) u_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_slow_tick(i_slow_tick), .i_main_tick(i_main_tick), .i_pll_tick(i_pll_tick),
  .o_master_tick(o_master_tick), .o_prog_tick(o_prog_tick), .o_irq(o_irq));

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`include "mpcs_consts.svh"

module tb_top
  import mpcs_pkg::*;
;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_slow_tick = 1'b0, i_main_tick = 1'b0, i_pll_tick = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic        o_master_tick, o_irq;
  logic [2:0]  o_prog_tick;
  logic [1:0]  tcnt = 2'h0;
  int          n_fail = 0, check_count = 0;

  always #12.5 i_clk = ~i_clk;

  // Slow every 4 cycles, main every 2, PLL every cycle
  always @(posedge i_clk) begin
    tcnt <= tcnt + 2'h1;
    i_slow_tick <= (tcnt == 2'h3);
    i_main_tick <= tcnt[0];
    i_pll_tick <= 1'b1;
  end

  mpcs_top #(.NUM_PCK(3)) u_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_slow_tick(i_slow_tick), .i_main_tick(i_main_tick), .i_pll_tick(i_pll_tick),
    .o_master_tick(o_master_tick), .o_prog_tick(o_prog_tick), .o_irq(o_irq));

  task automatic summarize();
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata & m, e);
  endtask : rdchk

  task automatic irqchk(input logic e);
    @(negedge i_clk);
    chk({31'h0, o_irq}, {31'h0, e});
  endtask : irqchk

  task automatic period(input int idx, input int exp);
    int n;
    n = 0;
    repeat (256) begin
      @(negedge i_clk);
      if ((idx == 3 ? o_master_tick : o_prog_tick[idx]) === 1'b1)
        n++;
    end
    chk(32'(n), 32'(exp));
  endtask : period

  task automatic setclk(input int idx, input logic [1:0] s, input logic [2:0] p, input int exp);
    mpcs_clk_cfg_s c;
    logic [7:0]    a;
    logic [31:0]   rb;
    c = '{prescale_select: p, clock_source_select: s};
    a = (idx == 3) ? `MPCS_ADDR_MCK_CFG : `MPCS_ADDR_PCK_BASE + 8'(idx * 4);
    rb = 32'h1 << ((idx == 3) ? 3 : 8 + idx);
    wr(a, {27'h0, c});
    // Read back at once so the checker sees a write followed by its read
    rdchk(a, 32'h1f, {27'h0, c});
    if (s == 2'h0)
      rdchk(`MPCS_ADDR_STATUS, rb, 32'h0);
    repeat (200) @(posedge i_clk);
    period(idx, exp);
    rdchk(`MPCS_ADDR_STATUS, rb, (exp != 0) ? rb : 32'h0);
  endtask : setclk

  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rdchk(`MPCS_ADDR_MASK_VIEW, 32'hffffffff, 32'h70d);
    repeat (20) @(posedge i_clk);
    rdchk(`MPCS_ADDR_STATUS, 32'hffffffff, 32'h708);
    rdchk(`MPCS_ADDR_EVENT, 32'h8, 32'h8);
    wr(`MPCS_ADDR_EVENT, 32'h8);
    rdchk(`MPCS_ADDR_EVENT, 32'h8, 32'h0);
    wr(8'h00, 32'hffffffff);
    rdchk(8'h00, 32'hffffffff, 32'h0);
    wr(`MPCS_ADDR_IRQ_SET, 32'h8);
    rdchk(`MPCS_ADDR_MASK_VIEW, 32'hffffffff, 32'h705);
    irqchk(1'b1);
    rdchk(`MPCS_ADDR_IRQ_SET, 32'hffffffff, 32'h0);
    rdchk(`MPCS_ADDR_IRQ_CLR, 32'hffffffff, 32'h0);
    wr(`MPCS_ADDR_IRQ_SET, 32'h0);
    wr(`MPCS_ADDR_IRQ_CLR, 32'h0);
    rdchk(`MPCS_ADDR_MASK_VIEW, 32'hffffffff, 32'h705);
    wr(`MPCS_ADDR_IRQ_CLR, 32'h70d);
    rdchk(`MPCS_ADDR_MASK_VIEW, 32'hffffffff, 32'h70d);
    wr(`MPCS_ADDR_IRQ_SET, 32'h1);
    irqchk(1'b0);
    wr(`MPCS_ADDR_OSC_CTRL, 32'h2);
    rdchk(`MPCS_ADDR_STATUS, 32'h1, 32'h1);
    irqchk(1'b1);
    wr(`MPCS_ADDR_OSC_CTRL, 32'h0);
    rdchk(`MPCS_ADDR_STATUS, 32'h1, 32'h0);
    irqchk(1'b0);
    // Start-up of 2 x 8 slow ticks is 64 cycles at this tick rate
    wr(`MPCS_ADDR_OSC_CTRL, 32'h0201);
    repeat (50) @(posedge i_clk);
    rdchk(`MPCS_ADDR_STATUS, 32'h1, 32'h0);
    repeat (20) @(posedge i_clk);
    rdchk(`MPCS_ADDR_STATUS, 32'h1, 32'h1);
    wr(`MPCS_ADDR_PLL_CTRL, 32'h0a00);
    rdchk(`MPCS_ADDR_STATUS, 32'h4, 32'h0);
    repeat (25) @(posedge i_clk);
    rdchk(`MPCS_ADDR_STATUS, 32'h4, 32'h0);
    repeat (15) @(posedge i_clk);
    rdchk(`MPCS_ADDR_STATUS, 32'h4, 32'h4);
    setclk(3, 2'h1, 3'h0, 128);
    setclk(3, 2'h0, 3'h0, 64);
    for (int k = 0; k < 7; k++)
      setclk(3, 2'h3, 3'(k), 256 >> k);
    setclk(3, 2'h2, 3'h0, 0);
    setclk(3, 2'h3, 3'h7, 0);
    for (int i = 0; i < 3; i++)
      setclk(i, 2'h3, 3'(i + 1), 128 >> i);
    setclk(1, 2'h2, 3'h0, 0);
    summarize();
  end
endmodule : tb_top
